// file: rtl/adc_internal_clock_stream_sequencer.sv
// Converter end: continuous conversions with self-generated serial clock output
// Function
// - System holds clock-source select high for this mode
// - Works with chip select tied low permanently
// - Converting: serial clock, data, busy all high
// - Conversion done: clock, busy, data go low
// - Sleep about 500ns, then output starts unprompted
// - Output starts first rising edge, ends after 32nd
// - Data changes on falling edge; clock driven out
// - Receiver samples on rising edges, bits 1..32
// - After 32nd rise: data high, convert, clock high
// - Oversample ratio 64 to 32768 sets conversion length
// - Null frequency is sample rate over ratio
// - Grounded conversion clock pin: internal 1.8MHz rate
// - External conversion clock divided by five
// - Word rate is null frequency over eight
// - Controller programs ratio serially; device adopts it
// - Ratio change leaves modulator sample rate alone
// - Thirteen input bits; early abort keeps old settings
// - Chip select high during output aborts, reconverts
`timescale 1ns/1ns
`default_nettype none
module adc_internal_clock_stream_sequencer import adc_seq_pkg::*; #(
  parameter int NULLS_PER_WORD = NULL_PER_WORD
) (
  input wire logic clk,
  input wire logic reset,
  adc_stream_if.device link,
  input wire logic [FRAME_BITS-2:0] conv_result,
  output logic [OSR_CODE_W-1:0] osr_code,
  output logic [CHAN_W-1:0] channel_sel,
  output logic fs_tick,
  output logic null_tick,
  output logic word_done
);
  typedef struct packed {
    dev_phase_t phase;
    logic sck_r;
    logic busy_r;
    logic [FRAME_BITS-1:0] frame;
    logic [5:0] bit_cnt;
    logic [3:0] div_cnt;
    logic [3:0] wait_cnt;
    logic [CFG_BITS-1:0] cfg_sh;
    logic [OSR_CODE_W-1:0] osr_code_r;
    logic [CHAN_W-1:0] chan_r;
    logic [14:0] null_cnt;
    logic [3:0] word_cnt;
    logic [6:0] acc;
    logic cclk_prev;
    logic [2:0] cclk_cnt;
    logic [6:0] idle_cnt;
    logic fs_r;
    logic null_r;
    logic done_r;
  } dev_state_t;

  localparam dev_state_t RST_STATE = '{
    phase: CONVERT, sck_r: 1'b1, busy_r: 1'b1, frame: '1, bit_cnt: '0, div_cnt: '0,
    wait_cnt: '0, cfg_sh: '0, osr_code_r: OSR_CODE_RST, chan_r: '0, null_cnt: '0,
    word_cnt: '0, acc: '0, cclk_prev: 1'b0, cclk_cnt: '0, idle_cnt: EXT_IDLE_CYC,
    fs_r: 1'b0, null_r: 1'b0, done_r: 1'b0};

  dev_state_t s_r;
  dev_state_t s_nxt;

  // Last sample count of one null period for a ratio code
  function automatic logic [14:0] osr_last(input logic [OSR_CODE_W-1:0] code);
    logic [15:0] oversample_ratio;
    oversample_ratio = OSR_MIN << code;
    return 15'(oversample_ratio - 16'h0001);
  endfunction : osr_last

  // Ratio code field once twelve configuration bits are in
  function automatic logic [OSR_CODE_W-1:0] cfg_ratio(input logic [CFG_BITS-1:0] sh);
    return sh[CFG_BITS-2:CHAN_W-1];
  endfunction : cfg_ratio

  always_comb begin
    logic tick;
    logic cclk_rise;
    logic [7:0] acc_sum;
    tick = 1'b0;
    cclk_rise = link.conversion_clock_pin & ~s_r.cclk_prev;
    acc_sum = {1'b0, s_r.acc} + {1'b0, FS_ACC_STEP};
    s_nxt = s_r;
    s_nxt.null_r = 1'b0;
    s_nxt.done_r = 1'b0;
    s_nxt.cclk_prev = link.conversion_clock_pin;
    // Pin counts as grounded once it stops toggling
    if (cclk_rise) begin
      s_nxt.idle_cnt = '0;
    end else if (s_r.idle_cnt != EXT_IDLE_CYC) begin
      s_nxt.idle_cnt = s_r.idle_cnt + 7'h01;
    end
    if (s_r.idle_cnt != EXT_IDLE_CYC) begin
      if (cclk_rise) begin
        if (s_r.cclk_cnt == CCLK_DIV - 3'h1) begin
          s_nxt.cclk_cnt = '0;
          tick = 1'b1;
        end else begin
          s_nxt.cclk_cnt = s_r.cclk_cnt + 3'h1;
        end
      end
    end else begin
      s_nxt.cclk_cnt = '0;
      if (acc_sum >= {1'b0, FS_ACC_MOD}) begin
        s_nxt.acc = 7'(acc_sum - {1'b0, FS_ACC_MOD});
        tick = 1'b1;
      end else begin
        s_nxt.acc = acc_sum[6:0];
      end
    end
    // Sample rate above never depends on the ratio code
    s_nxt.fs_r = tick;
    unique case (s_r.phase)
      CONVERT: begin
        if (tick) begin
          if (s_r.null_cnt == osr_last(s_r.osr_code_r)) begin
            s_nxt.null_cnt = '0;
            s_nxt.null_r = 1'b1;
            if (s_r.word_cnt == 4'(NULLS_PER_WORD - 1)) begin
              s_nxt.word_cnt = '0;
              s_nxt.phase = SLEEP;
              s_nxt.sck_r = 1'b0;
              s_nxt.busy_r = 1'b0;
              s_nxt.frame = {1'b0, conv_result};
              s_nxt.wait_cnt = '0;
              s_nxt.done_r = 1'b1;
            end else begin
              s_nxt.word_cnt = s_r.word_cnt + 4'h1;
            end
          end else begin
            s_nxt.null_cnt = s_r.null_cnt + 15'h0001;
          end
        end
      end
      SLEEP: begin
        if (link.cs_n || !link.clock_source_select_n) begin
          s_nxt.wait_cnt = '0;
        end else if (s_r.wait_cnt == 4'(SLEEP_CYC - 1)) begin
          s_nxt.phase = SHIFT;
          s_nxt.div_cnt = '0;
          s_nxt.bit_cnt = '0;
        end else begin
          s_nxt.wait_cnt = s_r.wait_cnt + 4'h1;
        end
      end
      SHIFT: begin
        if (link.cs_n) begin
          s_nxt.phase = CONVERT;
          s_nxt.sck_r = 1'b1;
          s_nxt.busy_r = 1'b1;
          s_nxt.frame = '1;
        end else if (s_r.div_cnt != SCK_HALF_CYC - 4'h1) begin
          s_nxt.div_cnt = s_r.div_cnt + 4'h1;
        end else begin
          s_nxt.div_cnt = '0;
          if (!s_r.sck_r) begin
            s_nxt.sck_r = 1'b1;
            s_nxt.bit_cnt = s_r.bit_cnt + 6'h01;
            if (s_r.bit_cnt < 6'(CFG_BITS)) begin
              s_nxt.cfg_sh = {s_r.cfg_sh[CFG_BITS-2:0], link.sdi};
            end
            if (s_r.bit_cnt == 6'(CFG_BITS - 1)) begin
              // Settings change only once all thirteen bits are in
              if (cfg_ratio(s_r.cfg_sh) <= OSR_CODE_MAX) begin
                s_nxt.osr_code_r = cfg_ratio(s_r.cfg_sh);
              end
              s_nxt.chan_r = {s_r.cfg_sh[CHAN_W-2:0], link.sdi};
            end
          end else if (s_r.bit_cnt == 6'(FRAME_BITS)) begin
            s_nxt.phase = CONVERT;
            s_nxt.busy_r = 1'b1;
            s_nxt.frame = '1;
          end else begin
            s_nxt.sck_r = 1'b0;
            s_nxt.frame = {s_r.frame[FRAME_BITS-2:0], 1'b1};
          end
        end
      end
      default: begin
        s_nxt = RST_STATE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      s_r <= RST_STATE;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Clock, data and busy pins come straight from state flip-flops; sdo_oe follows cs_n directly
  assign link.sck = s_r.sck_r;
  assign link.sdo = s_r.frame[FRAME_BITS-1];
  assign link.busy = s_r.busy_r;
  assign link.sdo_oe = ~link.cs_n;
  assign osr_code = s_r.osr_code_r;
  assign channel_sel = s_r.chan_r;
  assign fs_tick = s_r.fs_r;
  assign null_tick = s_r.null_r;
  assign word_done = s_r.done_r;
endmodule : adc_internal_clock_stream_sequencer
`default_nettype wire

// file: rtl/adc_result_capture_controller.sv
// Controller end: captures result frames and programs ratio and channel
`timescale 1ns/1ns
`default_nettype none
module adc_result_capture_controller import adc_seq_pkg::*; (
  input wire logic clk,
  input wire logic reset,
  adc_stream_if.controller link,
  input wire logic [OSR_CODE_W-1:0] osr_code_in,
  input wire logic [CHAN_W-1:0] channel_in,
  input wire logic ext_clk_en,
  input wire logic abort_req,
  output logic [FRAME_BITS-1:0] frame_data,
  output logic frame_valid
);
  typedef struct packed {
    logic sck_prev;
    logic busy_prev;
    logic [FRAME_BITS-1:0] cap;
    logic [5:0] cap_cnt;
    logic [CFG_BITS-1:0] sdi_sh;
    logic [3:0] cclk_cnt;
    logic cclk_r;
    logic [FRAME_BITS-1:0] frame_r;
    logic valid_r;
  } ctl_state_t;

  localparam ctl_state_t RST_STATE = '{
    sck_prev: 1'b1, busy_prev: 1'b1, cap: '0, cap_cnt: '0, sdi_sh: '0, cclk_cnt: '0,
    cclk_r: 1'b0, frame_r: '0, valid_r: 1'b0};

  ctl_state_t s_r;
  ctl_state_t s_nxt;

  always_comb begin
    s_nxt = s_r;
    s_nxt.valid_r = 1'b0;
    s_nxt.sck_prev = link.sck;
    s_nxt.busy_prev = link.busy;
    // Optional external conversion clock, else pin held low
    if (!ext_clk_en) begin
      s_nxt.cclk_cnt = '0;
      s_nxt.cclk_r = 1'b0;
    end else if (s_r.cclk_cnt == 4'(CCLK_HALF_CYC - 1)) begin
      s_nxt.cclk_cnt = '0;
      s_nxt.cclk_r = ~s_r.cclk_r;
    end else begin
      s_nxt.cclk_cnt = s_r.cclk_cnt + 4'h1;
    end
    if (s_r.busy_prev && !link.busy) begin
      s_nxt.sdi_sh = {osr_code_in, channel_in};
      s_nxt.cap_cnt = '0;
    end else if (link.sck && !s_r.sck_prev && !link.busy) begin
      s_nxt.cap = {s_r.cap[FRAME_BITS-2:0], link.sdo_line};
      s_nxt.cap_cnt = s_r.cap_cnt + 6'h01;
      s_nxt.sdi_sh = {s_r.sdi_sh[CFG_BITS-2:0], 1'b0};
      if (s_r.cap_cnt == 6'(FRAME_BITS - 1)) begin
        s_nxt.frame_r = {s_r.cap[FRAME_BITS-2:0], link.sdo_line};
        s_nxt.valid_r = 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      s_r <= RST_STATE;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign link.clock_source_select_n = 1'b1;
  assign link.cs_n = abort_req;
  assign link.sdi = s_r.sdi_sh[CFG_BITS-1];
  assign link.conversion_clock_pin = s_r.cclk_r;
  assign frame_data = s_r.frame_r;
  assign frame_valid = s_r.valid_r;
endmodule : adc_result_capture_controller
`default_nettype wire

// file: rtl/adc_seq_pkg.sv
// Shared constants and types for the conversion stream sequencer and its controller
package adc_seq_pkg;
  localparam int CLK_HZ = 10_000_000;
  localparam int CLK_NS = 100;
  localparam int SLEEP_NS = 500;
  localparam int SLEEP_CYC = (SLEEP_NS + CLK_NS - 1) / CLK_NS;
  localparam int FRAME_BITS = 32;
  localparam int CFG_BITS = 13;
  localparam int OSR_CODE_W = 4;
  localparam int CHAN_W = CFG_BITS - OSR_CODE_W;
  localparam logic [3:0] OSR_CODE_MAX = 4'h9;
  localparam logic [3:0] OSR_CODE_RST = 4'h0;
  localparam logic [15:0] OSR_MIN = 16'h0040;
  localparam int FS_INT_HZ = 1_800_000;
  localparam int ACC_UNIT_HZ = 100_000;
  localparam logic [6:0] FS_ACC_STEP = 7'(FS_INT_HZ / ACC_UNIT_HZ);
  localparam logic [6:0] FS_ACC_MOD = 7'(CLK_HZ / ACC_UNIT_HZ);
  localparam logic [2:0] CCLK_DIV = 3'h5;
  localparam int NULL_PER_WORD = 8;
  localparam logic [3:0] SCK_HALF_CYC = 4'h2;
  localparam logic [6:0] EXT_IDLE_CYC = 7'h40;
  localparam int CCLK_HALF_CYC = 5;
  typedef enum logic [1:0] {CONVERT, SLEEP, SHIFT} dev_phase_t;
endpackage : adc_seq_pkg

// file: rtl/adc_stream_if.sv
// Pin bundle between the converter sequencer and the result-capturing controller
`timescale 1ns/1ns
`default_nettype none
interface adc_stream_if;
  logic sck;
  logic sdo;
  logic sdo_oe;
  logic sdo_line;
  logic busy;
  logic cs_n;
  logic sdi;
  logic clock_source_select_n;
  logic conversion_clock_pin;
  // Undriven data line is pulled high
  assign sdo_line = sdo_oe ? sdo : 1'b1;
  modport device (output sck, output sdo, output sdo_oe, output busy, input cs_n, input sdi,
    input clock_source_select_n, input conversion_clock_pin);
  modport controller (input sck, input sdo_line, input busy, output cs_n, output sdi,
    output clock_source_select_n, output conversion_clock_pin);
endinterface : adc_stream_if
`default_nettype wire

// file: testbench/adc_internal_clock_stream_sequencer_bench.sv
// Testbench joining converter and controller ends
`timescale 1ns/1ns
`default_nettype none
module adc_internal_clock_stream_sequencer_bench import adc_seq_pkg::*;;
  logic clk, reset, fs_tick, null_tick, word_done, ext_clk_en, abort_req, frame_valid;
  logic [FRAME_BITS-2:0] conv_result;
  logic [OSR_CODE_W-1:0] osr_code, osr_code_in;
  logic [CHAN_W-1:0] channel_sel, channel_in;
  logic [FRAME_BITS-1:0] frame_data;
  int fails = 0;
  int n_checks = 0;
  int fs_n, null_n, conv_n, done_n;
  adc_stream_if link();
  adc_internal_clock_stream_sequencer #(.NULLS_PER_WORD(2)) i_adc_internal_clock_stream_sequencer (
    .clk(clk), .reset(reset), .link(link), .conv_result(conv_result), .osr_code(osr_code),
    .channel_sel(channel_sel), .fs_tick(fs_tick), .null_tick(null_tick), .word_done(word_done));
  adc_result_capture_controller i_adc_result_capture_controller (.clk(clk), .reset(reset),
    .link(link), .osr_code_in(osr_code_in), .channel_in(channel_in), .ext_clk_en(ext_clk_en),
    .abort_req(abort_req), .frame_data(frame_data), .frame_valid(frame_valid));
  adc_seq_assertions i_adc_seq_assertions (.clk(clk), .reset(reset), .sck(link.sck),
    .sdo(link.sdo), .sdo_oe(link.sdo_oe), .sdo_line(link.sdo_line), .busy(link.busy),
    .cs_n(link.cs_n), .sdi(link.sdi), .clock_source_select_n(link.clock_source_select_n),
    .conversion_clock_pin(link.conversion_clock_pin));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic complete_run;
    if (fails == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : complete_run
  task automatic wait_busy(input logic lvl);
    int n;
    n = 0;
    while (link.busy !== lvl && n < 20000) begin
      @(negedge clk);
      n++;
    end
  endtask : wait_busy
  task automatic wait_frame;
    int n;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (frame_valid !== 1'b1 && n < 20000);
    check(frame_data, {1'b0, conv_result});
  endtask : wait_frame
  // Counts sample ticks in a 300-cycle window and null ticks over one conversion
  task automatic measure(input int fs_exp);
    wait_busy(1'b0);
    wait_busy(1'b1);
    fs_n = 0;
    null_n = 0;
    conv_n = 0;
    done_n = 0;
    repeat (300) begin
      @(negedge clk);
      fs_n += int'(fs_tick);
      conv_n += int'(fs_tick);
      null_n += int'(null_tick);
    end
    while (link.busy === 1'b1) begin
      @(negedge clk);
      conv_n += int'(fs_tick);
      null_n += int'(null_tick);
      done_n += int'(word_done);
    end
    repeat (4) begin
      @(negedge clk);
      null_n += int'(null_tick);
      done_n += int'(word_done);
    end
    check(32'(fs_n), 32'(fs_exp));
    check(32'(null_n), 32'h2);
    check(32'(conv_n), 32'h100);
    check(32'(done_n), 32'h1);
  endtask : measure
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    repeat (60000) @(posedge clk);
    fails++;
    complete_run();
  end
  initial begin
    reset = 1'b1;
    conv_result = 31'h2a5c_3c96;
    osr_code_in = 4'h1;
    channel_in = 9'h0a5;
    ext_clk_en = 1'b0;
    abort_req = 1'b0;
    repeat (10) @(negedge clk);
    check(32'({link.busy, link.sck, link.sdo_line}), 32'h7);
    check(32'(osr_code), 32'h0);
    reset = 1'b0;
    wait_frame();
    check(32'(osr_code), 32'h1);
    check(32'(channel_sel), 32'h0a5);
    conv_result = 31'h55a3_c30f;
    wait_frame();
    channel_in = 9'h15a;
    measure(54);
    wait_busy(1'b0);
    repeat (20) @(negedge clk);
    abort_req = 1'b1;
    repeat (2) @(negedge clk);
    check(32'(link.busy), 32'h1);
    check(32'(channel_sel), 32'h0a5);
    abort_req = 1'b0;
    ext_clk_en = 1'b1;
    measure(6);
    check(32'(channel_sel), 32'h15a);
    complete_run();
  end
endmodule : adc_internal_clock_stream_sequencer_bench
`default_nettype wire

// file: testbench/adc_seq_assertions.sv
// Timing checks on the converter-to-controller serial link
`timescale 1ns/1ns
`default_nettype none
module adc_seq_assertions (
  input wire logic clk,
  input wire logic reset,
  input wire logic sck,
  input wire logic sdo,
  input wire logic sdo_oe,
  input wire logic sdo_line,
  input wire logic busy,
  input wire logic cs_n,
  input wire logic sdi,
  input wire logic clock_source_select_n,
  input wire logic conversion_clock_pin
);
  logic [5:0] rise_cnt_r;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // Counts clock rises in one output cycle
  always_ff @(posedge clk) begin
    if (reset || busy) begin
      rise_cnt_r <= 6'h00;
    end else if ($rose(sck)) begin
      rise_cnt_r <= rise_cnt_r + 6'h01;
    end
  end
  a_convert_all_high: assert property (busy |-> sck && sdo_line)
    else $error("converting without high lines");
  a_done_all_low: assert property ($fell(busy) && !cs_n |-> !sck && !sdo_line)
    else $error("end of conversion lines not low");
  a_sleep_then_shift: assert property ($fell(busy) && !cs_n |-> !sck [*6] ##[1:4] sck)
    else $error("sleep length wrong");
  a_sck_half_period: assert property (disable iff (reset || cs_n)
    $fell(sck) && !$past(busy) |-> !sck ##1 !sck ##1 sck)
    else $error("serial clock period wrong");
  a_data_on_fall: assert property ($changed(sdo) |-> $fell(sck) || $changed(busy))
    else $error("data changed off falling edge");
  a_frame_rises: assert property ($rose(busy) && !cs_n |-> rise_cnt_r == 6'h20)
    else $error("frame rise count wrong");
  a_end_of_frame: assert property ($rose(sck) && !busy && rise_cnt_r == 6'h1f |->
    sck [*2] ##[0:1] (busy && sdo_line))
    else $error("no restart after last rise");
  a_abort_restart: assert property (!busy && rise_cnt_r != 6'h00 && cs_n |=> busy)
    else $error("abort did not restart");
  a_select_high: assert property (clock_source_select_n)
    else $error("clock source select low");
  a_oe_follows_select: assert property (sdo_oe == !cs_n)
    else $error("data enable wrong");
  a_cfg_bit_steady: assert property ($rose(sck) && !busy |-> $stable(sdi))
    else $error("config bit moved at clock rise");
  a_conv_clock_period: assert property ($rose(conversion_clock_pin) |->
    conversion_clock_pin [*5] ##1 !conversion_clock_pin)
    else $error("conversion clock half period wrong");
  c_sleep: cover property ($fell(busy));
  c_frame: cover property ($rose(busy) && rise_cnt_r == 6'h20);
  c_abort: cover property (!busy && rise_cnt_r != 6'h00 && cs_n);
endmodule : adc_seq_assertions
`default_nettype wire
